// ==== logic/dpm_pkg.sv ====
package dpm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PEAK_PERIOD_S = 15;
    localparam int SLIDE_SHORT_S = 15;
    localparam int SLIDE_LONG_S = 60;
    localparam int SLIDE_LIMIT_MIN = 15;
    localparam int SEC_PER_MIN = 60;

    ////////////////////////////////////////////////////////////////////////////
    // Modbus frame addresses (register number minus one), first word of each pair; ADDR_RSVD_LAST and ADDR_LAST give the last word of a range
    localparam logic [15:0] ADDR_P_DMD = 16'h7da3;
    localparam logic [15:0] ADDR_Q_DMD = 16'h7da5;
    localparam logic [15:0] ADDR_S_DMD = 16'h7da7;
    localparam logic [15:0] ADDR_IA_PEAK = 16'h7da9;
    localparam logic [15:0] ADDR_IB_PEAK = 16'h7dab;
    localparam logic [15:0] ADDR_IC_PEAK = 16'h7dad;
    localparam logic [15:0] ADDR_IN_PEAK = 16'h7daf;
    localparam logic [15:0] ADDR_P_PEAK = 16'h7db1;
    localparam logic [15:0] ADDR_Q_PEAK = 16'h7db3;
    localparam logic [15:0] ADDR_S_PEAK = 16'h7db5;
    localparam logic [15:0] ADDR_GND_MAX = 16'h7db7;
    localparam logic [15:0] ADDR_LEAK_MAX = 16'h7db9;
    localparam logic [15:0] ADDR_RSVD_FIRST = 16'h7dbb;
    localparam logic [15:0] ADDR_RSVD_LAST = 16'h7dc0;
    localparam logic [15:0] ADDR_VAB_MAX = 16'h7dc1;
    localparam logic [15:0] ADDR_VBC_MAX = 16'h7dc3;
    localparam logic [15:0] ADDR_VCA_MAX = 16'h7dc5;
    localparam logic [15:0] ADDR_VAN_MAX = 16'h7dc7;
    localparam logic [15:0] ADDR_VBN_MAX = 16'h7dc9;
    localparam logic [15:0] ADDR_VCN_MAX = 16'h7dcb;
    localparam logic [15:0] ADDR_PF_A = 16'h7dcd;
    localparam logic [15:0] ADDR_PF_B = 16'h7dcf;
    localparam logic [15:0] ADDR_PF_C = 16'h7dd1;
    localparam logic [15:0] ADDR_PF_TOT = 16'h7dd3;
    localparam logic [15:0] ADDR_FPF_A = 16'h7dd5;
    localparam logic [15:0] ADDR_FPF_B = 16'h7dd7;
    localparam logic [15:0] ADDR_FPF_C = 16'h7dd9;
    localparam logic [15:0] ADDR_FPF_TOT = 16'h7ddb;
    localparam logic [15:0] ADDR_LAST = 16'h7ddc;

    ////////////////////////////////////////////////////////////////////////////
    // Values
    localparam logic [31:0] FLOAT_NA = 32'h7fc0_0000;
    localparam logic [31:0] VALUE_RST = 32'h0000_0000;
    localparam logic [15:0] RSVD_WORD = 16'h0000;
    localparam logic [7:0] SYS_TYPE_30 = 8'h1e;
    localparam logic [7:0] SYS_TYPE_40 = 8'h28;
    localparam logic [7:0] SYS_TYPE_41 = 8'h29;

    typedef enum logic [1:0] {
        DPM_UNIT_A = 2'b00,
        DPM_UNIT_E = 2'b01,
        DPM_UNIT_P = 2'b10,
        DPM_UNIT_H = 2'b11
    } dpm_unit_t;

    typedef enum logic {
        DPM_WIN_BLOCK = 1'b0,
        DPM_WIN_SLIDING = 1'b1
    } dpm_win_t;

    // Ordered compare of two FLOAT32 values; +0 and -0 count as distinct
    function automatic logic dpm_fp_gt(input logic [31:0] a, input logic [31:0] b);
        if (a[31] != b[31]) begin
            return !a[31];
        end
        if (!a[31]) begin
            return a[30:0] > b[30:0];
        end
        return a[30:0] < b[30:0];
    endfunction

endpackage

// ==== logic/dpm_refresh_timer.sv ====
module dpm_refresh_timer #(
    parameter int CYC_PER_SEC = dpm_pkg::CLK_HZ
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire dpm_pkg::dpm_win_t win_mode_i,
    input wire logic [7:0] win_min_i,
    output logic dmd_upd_o,
    output logic peak_upd_o
);
    import dpm_pkg::*;

    logic [31:0] cyc;
    logic [5:0] peak_s;
    logic [5:0] slide_s;
    logic [13:0] blk_s;
    logic [8:0] cfg_q;
    wire logic [8:0] cfg = {win_mode_i, win_min_i};
    wire logic cfg_chg = cfg != cfg_q;
    wire logic sec_tick = cyc == 32'(CYC_PER_SEC - 1);
    wire logic [7:0] min_eff = (win_min_i == 8'h00) ? 8'h01 : win_min_i;
    wire logic [5:0] slide_last = (int'(win_min_i) <= SLIDE_LIMIT_MIN) ?
        6'(SLIDE_SHORT_S - 1) : 6'(SLIDE_LONG_S - 1);
    wire logic [13:0] blk_last = 14'(int'(min_eff) * SEC_PER_MIN - 1);
    wire logic slide_end = slide_s >= slide_last;
    wire logic blk_end = blk_s >= blk_last;
    wire logic peak_end = peak_s == 6'(PEAK_PERIOD_S - 1);

    // A new window setting restarts the demand interval from zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc <= 32'h0000_0000;
            peak_s <= 6'h00;
            slide_s <= 6'h00;
            blk_s <= 14'h0000;
            cfg_q <= 9'h000;
            dmd_upd_o <= 1'b0;
            peak_upd_o <= 1'b0;
        end else begin
            cfg_q <= cfg;
            // Second counter runs free so the peak interval stays fixed across setting changes
            cyc <= sec_tick ? 32'h0000_0000 : cyc + 32'h0000_0001;
            peak_upd_o <= sec_tick && peak_end;
            dmd_upd_o <= sec_tick && !cfg_chg &&
                ((win_mode_i == DPM_WIN_BLOCK) ? blk_end : slide_end);
            if (sec_tick) begin
                peak_s <= peak_end ? 6'h00 : peak_s + 6'h01;
            end
            if (cfg_chg) begin
                slide_s <= 6'h00;
                blk_s <= 14'h0000;
            end else if (sec_tick) begin
                slide_s <= slide_end ? 6'h00 : slide_s + 6'h01;
                blk_s <= blk_end ? 14'h0000 : blk_s + 14'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval checks: cycles between two pulses under a steady setting
    logic [39:0] gap_dmd;
    logic [39:0] gap_peak;
    logic armed_dmd;
    logic armed_peak;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_dmd <= 40'h00_0000_0000;
            gap_peak <= 40'h00_0000_0000;
            armed_dmd <= 1'b0;
            armed_peak <= 1'b0;
        end else begin
            gap_dmd <= dmd_upd_o ? 40'h00_0000_0000 : gap_dmd + 40'h00_0000_0001;
            gap_peak <= peak_upd_o ? 40'h00_0000_0000 : gap_peak + 40'h00_0000_0001;
            armed_dmd <= cfg_chg ? 1'b0 : (dmd_upd_o || armed_dmd);
            armed_peak <= peak_upd_o || armed_peak;
        end
    end

    property p_slide_short;
        @(posedge clk_i) disable iff (!arst_n_i)
        dmd_upd_o && armed_dmd && !cfg_chg && win_mode_i == DPM_WIN_SLIDING &&
            int'(win_min_i) <= SLIDE_LIMIT_MIN
        |-> gap_dmd == 40'(longint'(SLIDE_SHORT_S) * CYC_PER_SEC - 1);
    endproperty
    a_slide_short: assert property (p_slide_short) else $error("short slide period wrong");

    property p_slide_long;
        @(posedge clk_i) disable iff (!arst_n_i)
        dmd_upd_o && armed_dmd && !cfg_chg && win_mode_i == DPM_WIN_SLIDING &&
            int'(win_min_i) > SLIDE_LIMIT_MIN
        |-> gap_dmd == 40'(longint'(SLIDE_LONG_S) * CYC_PER_SEC - 1);
    endproperty
    a_slide_long: assert property (p_slide_long) else $error("long slide period wrong");

    property p_peak_period;
        @(posedge clk_i) disable iff (!arst_n_i)
        peak_upd_o && armed_peak |-> gap_peak == 40'(longint'(PEAK_PERIOD_S) * CYC_PER_SEC - 1);
    endproperty
    a_peak_period: assert property (p_peak_period) else $error("peak refresh period wrong");

endmodule

// ==== logic/dpm_peak_track.sv ====
module dpm_peak_track #(
    parameter int N = 4
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clear_i,
    input wire logic sample_i,
    input wire logic [31:0] data_i [N],
    output logic [31:0] peak_o [N]
);
    import dpm_pkg::*;

    logic [N-1:0] seen;

    // A sample in the clear cycle survives: it becomes the first value tracked
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen <= '0;
            for (int i = 0; i < N; i++) begin
                peak_o[i] <= VALUE_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sample_i && (clear_i || !seen[i] || dpm_fp_gt(data_i[i], peak_o[i]))) begin
                    peak_o[i] <= data_i[i];
                    seen[i] <= 1'b1;
                end else if (clear_i) begin
                    peak_o[i] <= VALUE_RST;
                    seen[i] <= 1'b0;
                end
            end
        end
    end

    property p_restart;
        @(posedge clk_i) disable iff (!arst_n_i)
        sample_i && (clear_i || !seen[0]) |=> peak_o[0] == $past(data_i[0]);
    endproperty
    a_restart: assert property (p_restart) else $error("peak did not restart on sample");

endmodule

// ==== logic/dpm_regs.sv ====
module dpm_regs #(
    parameter int CYC_PER_SEC = dpm_pkg::CLK_HZ
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic rd_req_i,
    input wire logic [15:0] rd_addr_i,
    output logic rd_valid_o,
    output logic rd_err_o,
    output logic [15:0] rd_data_o,
    input wire logic rst_minmax_i,
    input wire dpm_pkg::dpm_win_t win_mode_i,
    input wire logic [7:0] win_min_i,
    input wire logic [7:0] sys_type_i,
    input wire dpm_pkg::dpm_unit_t unit_type_i,
    input wire logic [31:0] pwr_dmd_i [3],
    input wire logic [31:0] cur_dmd_i [4],
    input wire logic cur_dmd_valid_i,
    input wire logic meas_valid_i,
    input wire logic [31:0] gnd_cur_i,
    input wire logic [31:0] leak_cur_i,
    input wire logic [31:0] volt_i [6],
    input wire logic [31:0] pf_i [4],
    input wire logic [31:0] fpf_i [4],
    output logic dmd_upd_o,
    output logic peak_upd_o
);
    import dpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Refresh timing

    logic dmd_upd;
    logic peak_upd;

    dpm_refresh_timer #(
        .CYC_PER_SEC(CYC_PER_SEC)
    ) u_timer (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .win_mode_i(win_mode_i),
        .win_min_i(win_min_i),
        .dmd_upd_o(dmd_upd),
        .peak_upd_o(peak_upd)
    );

    assign dmd_upd_o = dmd_upd;
    assign peak_upd_o = peak_upd;

    ////////////////////////////////////////////////////////////////////////////
    // Demand and power factor snapshots

    logic [31:0] pwr_dmd_q [3];
    logic [31:0] pf_q [4];
    logic [31:0] fpf_q [4];

    // Demand only moves on a refresh pulse, so a client sees one value per interval
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                pwr_dmd_q[i] <= VALUE_RST;
            end
        end else if (dmd_upd) begin
            for (int i = 0; i < 3; i++) begin
                pwr_dmd_q[i] <= pwr_dmd_i[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                pf_q[i] <= VALUE_RST;
                fpf_q[i] <= VALUE_RST;
            end
        end else if (meas_valid_i) begin
            for (int i = 0; i < 4; i++) begin
                pf_q[i] <= pf_i[i];
                fpf_q[i] <= fpf_i[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peak and maximum trackers

    logic [31:0] cur_peak [4];
    logic [31:0] pwr_peak [3];
    logic [31:0] max_val [8];
    wire logic [31:0] max_in [8];

    assign max_in = '{gnd_cur_i, leak_cur_i, volt_i[0], volt_i[1],
                      volt_i[2], volt_i[3], volt_i[4], volt_i[5]};

    dpm_peak_track #(
        .N(4)
    ) u_cur_peak (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(rst_minmax_i),
        .sample_i(cur_dmd_valid_i),
        .data_i(cur_dmd_i),
        .peak_o(cur_peak)
    );

    // Power peaks follow the live demand at the fixed interval, not the window
    dpm_peak_track #(
        .N(3)
    ) u_pwr_peak (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(rst_minmax_i),
        .sample_i(peak_upd),
        .data_i(pwr_dmd_i),
        .peak_o(pwr_peak)
    );

    dpm_peak_track #(
        .N(8)
    ) u_max (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(rst_minmax_i),
        .sample_i(meas_valid_i),
        .data_i(max_in),
        .peak_o(max_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Availability by system wiring and protection unit

    wire logic neutral_ok = sys_type_i == SYS_TYPE_30 || sys_type_i == SYS_TYPE_41;
    wire logic ph_n_ok = sys_type_i == SYS_TYPE_40 || sys_type_i == SYS_TYPE_41;
    wire logic unit_eph = unit_type_i != DPM_UNIT_A;
    wire logic unit_ph = unit_type_i == DPM_UNIT_P || unit_type_i == DPM_UNIT_H;
    wire logic unit_h = unit_type_i == DPM_UNIT_H;

    ////////////////////////////////////////////////////////////////////////////
    // Read decode

    // Frame address is used directly; the first address of a pair is the high word
    wire logic [15:0] off = rd_addr_i - ADDR_P_DMD;
    wire logic half_lo = off[0];
    wire logic [15:0] pair_addr = rd_addr_i - {15'h0000, half_lo};
    wire logic in_range = rd_addr_i >= ADDR_P_DMD && rd_addr_i <= ADDR_LAST;
    wire logic in_rsvd = rd_addr_i >= ADDR_RSVD_FIRST && rd_addr_i <= ADDR_RSVD_LAST;
    logic [31:0] sel_word;

    // Unavailable quantities read as a quiet NaN rather than a stale number
    always_comb begin
        case (pair_addr)
            ADDR_P_DMD: sel_word = unit_eph ? pwr_dmd_q[0] : FLOAT_NA;
            ADDR_Q_DMD: sel_word = unit_ph ? pwr_dmd_q[1] : FLOAT_NA;
            ADDR_S_DMD: sel_word = unit_ph ? pwr_dmd_q[2] : FLOAT_NA;
            ADDR_IA_PEAK: sel_word = cur_peak[0];
            ADDR_IB_PEAK: sel_word = cur_peak[1];
            ADDR_IC_PEAK: sel_word = cur_peak[2];
            ADDR_IN_PEAK: sel_word = neutral_ok ? cur_peak[3] : FLOAT_NA;
            ADDR_P_PEAK: sel_word = pwr_peak[0];
            ADDR_Q_PEAK: sel_word = pwr_peak[1];
            ADDR_S_PEAK: sel_word = pwr_peak[2];
            ADDR_GND_MAX: sel_word = max_val[0];
            ADDR_LEAK_MAX: sel_word = max_val[1];
            ADDR_VAB_MAX: sel_word = max_val[2];
            ADDR_VBC_MAX: sel_word = max_val[3];
            ADDR_VCA_MAX: sel_word = max_val[4];
            ADDR_VAN_MAX: sel_word = ph_n_ok ? max_val[5] : FLOAT_NA;
            ADDR_VBN_MAX: sel_word = ph_n_ok ? max_val[6] : FLOAT_NA;
            ADDR_VCN_MAX: sel_word = ph_n_ok ? max_val[7] : FLOAT_NA;
            ADDR_PF_A: sel_word = ph_n_ok ? pf_q[0] : FLOAT_NA;
            ADDR_PF_B: sel_word = ph_n_ok ? pf_q[1] : FLOAT_NA;
            ADDR_PF_C: sel_word = ph_n_ok ? pf_q[2] : FLOAT_NA;
            ADDR_PF_TOT: sel_word = pf_q[3];
            ADDR_FPF_A: sel_word = (unit_h && ph_n_ok) ? fpf_q[0] : FLOAT_NA;
            ADDR_FPF_B: sel_word = (unit_h && ph_n_ok) ? fpf_q[1] : FLOAT_NA;
            ADDR_FPF_C: sel_word = (unit_h && ph_n_ok) ? fpf_q[2] : FLOAT_NA;
            ADDR_FPF_TOT: sel_word = unit_h ? fpf_q[3] : FLOAT_NA;
            default: sel_word = FLOAT_NA;
        endcase
    end

    wire logic [15:0] sel_half = half_lo ? sel_word[15:0] : sel_word[31:16];
    wire logic [15:0] next_data = in_rsvd ? RSVD_WORD : sel_half;

    ////////////////////////////////////////////////////////////////////////////
    // Read answer: one cycle after the request, nothing else changes state

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_err_o <= 1'b0;
            rd_data_o <= 16'h0000;
        end else begin
            rd_valid_o <= rd_req_i;
            if (rd_req_i) begin
                rd_err_o <= !in_range;
                rd_data_o <= in_range ? next_data : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    wire logic [15:0] p_dmd_hi = pwr_dmd_q[0][31:16];
    wire logic [15:0] q_dmd_lo = pwr_dmd_q[1][15:0];

    sequence s_read_at(logic [15:0] a);
        rd_req_i && rd_addr_i == a;
    endsequence

    property p_read_answer;
        @(posedge clk_i) disable iff (!arst_n_i)
        rd_req_i |=> rd_valid_o && (rd_err_o == $past(!in_range));
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    property p_word_order;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_read_at(ADDR_P_DMD) and unit_eph |=> rd_data_o == $past(p_dmd_hi);
    endproperty
    a_word_order: assert property (p_word_order) else $error("high word not first");

    property p_unit_gate;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_read_at(ADDR_Q_DMD + 16'h0001) |=>
            rd_data_o == ($past(unit_ph) ? $past(q_dmd_lo) : FLOAT_NA[15:0]);
    endproperty
    a_unit_gate: assert property (p_unit_gate) else $error("reactive demand gating wrong");

    property p_block_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        win_mode_i == DPM_WIN_BLOCK && !dmd_upd |=>
            $stable(pwr_dmd_q[0]) && $stable(pwr_dmd_q[1]) && $stable(pwr_dmd_q[2]);
    endproperty
    a_block_hold: assert property (p_block_hold) else $error("demand moved between windows");

    property p_clr_cur;
        @(posedge clk_i) disable iff (!arst_n_i)
        rst_minmax_i && !cur_dmd_valid_i |=> cur_peak[0] == VALUE_RST &&
            cur_peak[1] == VALUE_RST && cur_peak[2] == VALUE_RST && cur_peak[3] == VALUE_RST;
    endproperty
    a_clr_cur: assert property (p_clr_cur) else $error("current peaks not cleared");

    property p_clr_pwr;
        @(posedge clk_i) disable iff (!arst_n_i)
        rst_minmax_i && !peak_upd |=> pwr_peak[0] == VALUE_RST &&
            pwr_peak[1] == VALUE_RST && pwr_peak[2] == VALUE_RST;
    endproperty
    a_clr_pwr: assert property (p_clr_pwr) else $error("power peaks not cleared");

    property p_clr_gnd;
        @(posedge clk_i) disable iff (!arst_n_i)
        rst_minmax_i && !meas_valid_i |=> max_val[0] == VALUE_RST && max_val[1] == VALUE_RST;
    endproperty
    a_clr_gnd: assert property (p_clr_gnd) else $error("fault current maxima not cleared");

    property p_clr_volt;
        @(posedge clk_i) disable iff (!arst_n_i)
        rst_minmax_i && !meas_valid_i |=> max_val[2] == VALUE_RST && max_val[3] == VALUE_RST &&
            max_val[4] == VALUE_RST && max_val[5] == VALUE_RST &&
            max_val[6] == VALUE_RST && max_val[7] == VALUE_RST;
    endproperty
    a_clr_volt: assert property (p_clr_volt) else $error("voltage maxima not cleared");

    property p_neutral_na;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_read_at(ADDR_IN_PEAK) and !neutral_ok |=> rd_data_o == FLOAT_NA[31:16];
    endproperty
    a_neutral_na: assert property (p_neutral_na) else $error("neutral peak shown");

    property p_phn_na;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_read_at(ADDR_VAN_MAX) and !ph_n_ok |=> rd_data_o == FLOAT_NA[31:16];
    endproperty
    a_phn_na: assert property (p_phn_na) else $error("phase-neutral max shown");

    property p_fpf_na;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_read_at(ADDR_FPF_TOT) and !unit_h |=> rd_data_o == FLOAT_NA[31:16];
    endproperty
    a_fpf_na: assert property (p_fpf_na) else $error("fundamental pf shown");

    property p_rsvd;
        @(posedge clk_i) disable iff (!arst_n_i)
        rd_req_i && in_rsvd |=> rd_data_o == RSVD_WORD && !rd_err_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not fixed");

endmodule

// ==== dv/dpm_client.sv ====
module dpm_client (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic rd_err_i,
    input wire logic [15:0] rd_data_i,
    output logic rd_req_o,
    output logic [15:0] rd_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 16'h0000;
    end
    // Address is inverted once taken so a stale sample cannot look right
    task automatic read16(input logic [15:0] a, output logic [15:0] d, output logic e,
                          output bit ok);
        ok = 1'b0;
        @(posedge clk_i);
        rd_req_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
        rd_addr_o <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk_i);
            if (rd_valid_i === 1'b1) begin
                ok = 1'b1;
                d = rd_data_i;
                e = rd_err_i;
            end
        end
    endtask
endmodule

// ==== dv/dpm_regs_test.sv ====
module dpm_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dpm_pkg::*;
    logic clk_i, arst_n_i, rd_req_i, rd_valid_o, rd_err_o, rst_minmax_i, cur_dmd_valid_i, e;
    logic meas_valid_i, dmd_upd_o, peak_upd_o;
    logic [15:0] rd_addr_i, rd_data_o, w;
    logic [7:0] win_min_i, sys_type_i;
    logic [31:0] pwr_dmd_i [3], cur_dmd_i [4], volt_i [6], pf_i [4], fpf_i [4];
    logic [31:0] gnd_cur_i, leak_cur_i, v;
    dpm_win_t win_mode_i;
    dpm_unit_t unit_type_i;
    int n_errors = 0, n_tests = 0, cyc = 0;
    localparam logic [15:0] CLR [6] = '{ADDR_IA_PEAK, ADDR_IN_PEAK, ADDR_P_PEAK,
        ADDR_LEAK_MAX, ADDR_VAB_MAX, ADDR_VCN_MAX};
    localparam logic [15:0] NA [5] = '{ADDR_IN_PEAK, ADDR_VAN_MAX, ADDR_PF_A, ADDR_Q_DMD,
        ADDR_FPF_TOT};
    dpm_regs #(.CYC_PER_SEC(10)) i_dpm_regs (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_valid_o(rd_valid_o),
        .rd_err_o(rd_err_o), .rd_data_o(rd_data_o), .rst_minmax_i(rst_minmax_i),
        .win_mode_i(win_mode_i), .win_min_i(win_min_i), .sys_type_i(sys_type_i),
        .unit_type_i(unit_type_i), .pwr_dmd_i(pwr_dmd_i), .cur_dmd_i(cur_dmd_i),
        .cur_dmd_valid_i(cur_dmd_valid_i), .meas_valid_i(meas_valid_i), .gnd_cur_i(gnd_cur_i),
        .leak_cur_i(leak_cur_i), .volt_i(volt_i), .pf_i(pf_i), .fpf_i(fpf_i),
        .dmd_upd_o(dmd_upd_o), .peak_upd_o(peak_upd_o));
    dpm_client i_dpm_client (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_err_i(rd_err_o),
        .rd_data_i(rd_data_o), .rd_req_o(rd_req_i), .rd_addr_o(rd_addr_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] s, input logic [32:0] x);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic results();
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rd16(input logic [15:0] a);
        bit ok;
        i_dpm_client.read16(a, w, e, ok);
        if (!ok) begin
            check(33'h1, 33'h0);
            results();
        end
    endtask
    // No snapshot between halves, so only read pairs while the source is quiet
    task automatic rd32(input logic [15:0] a, input logic [31:0] x);
        rd16(a);
        v[31:16] = w;
        rd16(a + 16'h0001);
        check({e, v[31:16], w}, {1'b0, x});
    endtask
    task automatic wait_pulse(input bit p);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(negedge clk_i);
            if ((p ? peak_upd_o : dmd_upd_o) === 1'b1) break;
        end
        if (i == 2000) begin
            check(33'h1, 33'h0);
            results();
        end
    endtask
    task automatic gap(input bit p, input int x);
        int t;
        wait_pulse(p);
        t = cyc;
        wait_pulse(p);
        check(33'(cyc - t), 33'(x));
    endtask
    task automatic pulse(input bit clr);
        @(posedge clk_i);
        meas_valid_i <= !clr;
        cur_dmd_valid_i <= !clr;
        rst_minmax_i <= clr;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        cur_dmd_valid_i <= 1'b0;
        rst_minmax_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;
    initial begin
        arst_n_i = 1'b0;
        rst_minmax_i = 1'b0;
        meas_valid_i = 1'b0;
        cur_dmd_valid_i = 1'b0;
        win_mode_i = DPM_WIN_SLIDING;
        win_min_i = 8'h0f;
        sys_type_i = SYS_TYPE_41;
        unit_type_i = DPM_UNIT_H;
        pwr_dmd_i = '{32'h4100_0000, 32'h4200_0000, 32'h4300_0000};
        cur_dmd_i = '{4{32'h4400_0000}};
        volt_i = '{6{32'h4400_0000}};
        pf_i = '{4{32'h3f00_0000}};
        fpf_i = '{4{32'h3f00_0000}};
        gnd_cur_i = 32'h4000_0000;
        leak_cur_i = 32'h4000_0000;
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int a = 16'h7dbb; a <= 16'h7dc0; a++) begin
            rd16(16'(a));
            check({e, w}, 33'h0);
        end
        rd16(16'h7ddd);
        check({e, w}, 33'h1_0000);
        pulse(1'b0);
        @(posedge clk_i);
        volt_i <= '{6{32'h4300_0000}};
        gnd_cur_i <= 32'h4100_0000;
        pulse(1'b0);
        rd32(ADDR_VAB_MAX, 32'h4400_0000);
        rd32(ADDR_GND_MAX, 32'h4100_0000);
        rd32(ADDR_IN_PEAK, 32'h4400_0000);
        rd32(ADDR_PF_A, 32'h3f00_0000);
        gap(1'b1, 150);
        rd32(ADDR_S_PEAK, 32'h4300_0000);
        pulse(1'b1);
        foreach (CLR[i]) rd32(CLR[i], 32'h0);
        pulse(1'b0);
        rd32(ADDR_VCN_MAX, 32'h4300_0000);
        gap(1'b0, 150);
        @(posedge clk_i);
        pwr_dmd_i[0] <= 32'h4500_0000;
        rd32(ADDR_P_DMD, 32'h4100_0000);
        wait_pulse(1'b0);
        rd32(ADDR_P_DMD, 32'h4500_0000);
        @(posedge clk_i);
        win_mode_i <= DPM_WIN_BLOCK;
        win_min_i <= 8'h02;
        gap(1'b0, 1200);
        @(posedge clk_i);
        win_mode_i <= DPM_WIN_SLIDING;
        win_min_i <= 8'h10;
        gap(1'b0, 600);
        @(posedge clk_i);
        sys_type_i <= 8'h00;
        unit_type_i <= DPM_UNIT_E;
        foreach (NA[i]) rd32(NA[i], FLOAT_NA);
        rd32(ADDR_P_DMD, 32'h4500_0000);
        results();
    end
endmodule
